/* File: rtl/reclose_monitor_cfg.svh */
`ifndef RECLOSE_MONITOR_CFG_SVH
`define RECLOSE_MONITOR_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CTRL          8'h00
`define REG_READY_TMO     8'h04
`define REG_EXT_LIMIT     8'h08
`define REG_TRIP_TMO      8'h0C
`define REG_HOLD_TIME     8'h10
`define REG_CYCLE_CTRL0   8'h14
`define REG_CYCLE_CTRL1   8'h18
`define REG_STATUS        8'h1C

// Fields of the control register.
`define CTRL_CHECK_BIT    0
`define CTRL_ZONE_BIT     1
`define CTRL_HS2_BIT      2
`define CTRL_HS3_BIT      3
`define CTRL_START_LO     4

// A trip timer setting of all ones means infinite.
`define TIMER_INFINITE    16'hFFFF

// Reset values of the timer settings, in time-base ticks.
`define READY_TMO_RST     16'h0064
`define EXT_LIMIT_RST     16'h00C8
`define TRIP_TMO_RST      16'h0032
`define HOLD_TIME_RST     16'h0064

// AXI response codes.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: rtl/reclose_monitor_pkg.sv */
package reclose_monitor_pkg;

   // Per-cycle control of one overcurrent element.
   typedef enum logic [1:0] {
      ctl_unaffected,
      ctl_instant,
      ctl_blocked,
      ctl_spare
   } elem_ctl_t;

   // Element control outputs for one cycle.
   typedef struct packed {
      elem_ctl_t phase_hi;
      elem_ctl_t ground_hi;
      elem_ctl_t phase_lo;
      elem_ctl_t ground_lo;
   } elem_set_t;

   // Reclose events from the sequencer outside.
   typedef struct packed {
      logic trip;
      logic breaker_open;
      logic dead_time_done;
      logic sync_release;
      logic close_done;
      logic restraint_done;
      logic extra_block;
   } seq_in_t;

   typedef enum logic [1:0] {
      st_normal,
      st_running,
      st_blocked
   } ar_state_t;

endpackage

/* File: rtl/reclose_monitor.sv */
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "reclose_monitor_cfg.svh"

// Notes on behaviour
// [RQ1] Checking on: every reclosure waits for ready.
// [RQ2] Ready input low starts ready timeout timer.
// [RQ3] Ready returns early: cancel timer, resume.
// [RQ4] Ready timer running extends dead time.
// [RQ5] Ready timeout with ready low: dynamic block.
// [RQ6] Extension limit timer starts at dead end.
// [RQ7] Sync release before limit: stop, close.
// [RQ8] Extension limit expires first: dynamic block.
// [RQ9] Software sets limit not below ready timeout.
// [RQ10] Trip starts trip-to-open timer.
// [RQ11] Trip timer expiry: breaker failure, block.
// [RQ12] Infinite trip timer setting disables monitoring.
// [RQ13] Each element: instant, unaffected or blocked.
// [RQ14] Ready and not-ready states drive cold load.
// [RQ15] Mode: high-set 2/3 always or when ready.
// [RQ16] Distinct zone release flag for cycles 1-4.
// [RQ17] Normal state applies starting-cycle control.
// [RQ18] Close command advances to next cycle control.
// [RQ19] Restraint expiry or unblock returns to normal.
// [RQ20] Element settings also govern zone sequencing.
// [RQ21] Zone sequencing: low-set dropout advances cycle.
// [RQ22] Each low-set dropout counts as an attempt.
// [RQ23] Block hold timer restarts while cause holds.
// [RQ24] Timers count tick, load, clear on reset.
module reclose_monitor
   import reclose_monitor_pkg::*;
#(
   parameter int TW = 16
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        tick,
   input  wire logic        general_reset,
   input  wire logic        breaker_ready_input,
   input  wire seq_in_t     seq_in,
   input  wire logic        low_set_pickup,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             close_command,
   output logic             dynamic_block_flag,
   output logic             breaker_failure,
   output logic             reclose_ready,
   output logic             reclose_not_ready,
   output logic             high_set2_enable,
   output logic             high_set3_enable,
   output logic [3:0]       cycle_zone_release_flag,
   output elem_set_t        elem_ctl
);

   // Settings.
   logic [7:0]    ctrl_q;
   logic [TW-1:0] ready_tmo_q;
   logic [TW-1:0] ext_limit_q;
   logic [TW-1:0] trip_tmo_q;
   logic [TW-1:0] hold_time_q;
   logic [15:0]   cyc_set_q [0:3];

   // Timers and state.
   logic [TW-1:0] ready_cnt_q;
   logic          ready_run_q;
   logic [TW-1:0] ext_cnt_q;
   logic          ext_run_q;
   logic [TW-1:0] trip_cnt_q;
   logic          trip_run_q;
   logic [TW-1:0] hold_cnt_q;
   logic          hold_run_q;
   logic          dead_wait_q;
   logic          ready_q;
   logic          pickup_q;
   logic [1:0]    cycle_q;
   ar_state_t     state_q;

   // AXI holding registers.
   logic          aw_got_q;
   logic          w_got_q;
   logic [7:0]    aw_addr_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;

   wire logic check_on = ctrl_q[`CTRL_CHECK_BIT];
   wire logic zone_on  = ctrl_q[`CTRL_ZONE_BIT];

   function automatic logic [TW-1:0] merge16(input logic [TW-1:0] old,
                                             input logic [31:0]   d,
                                             input logic [3:0]    s);
      logic [31:0] r;
      r = {{(32 - TW){1'b0}}, old};
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r[TW-1:0];
   endfunction

   function automatic logic expired(input logic run, input logic [TW-1:0] cnt);
      return run && tick && (cnt <= {{(TW-1){1'b0}}, 1'b1});
   endfunction

   wire logic ready_exp = expired(ready_run_q, ready_cnt_q);
   wire logic ext_exp   = expired(ext_run_q, ext_cnt_q);
   wire logic trip_exp  = expired(trip_run_q, trip_cnt_q);
   wire logic hold_exp  = expired(hold_run_q, hold_cnt_q);
   wire logic running   = (state_q == st_running);

   // Block causes raised in this cycle.
   wire logic ready_fail = ready_exp && !breaker_ready_input && check_on;  // [RQ5]
   wire logic ext_fail   = ext_exp && dead_wait_q;                         // [RQ8]
   wire logic new_cause  = ready_fail || ext_fail || trip_exp ||
                           (seq_in.extra_block && running);

   // Close may go once dead time is over, ready holds and sync grants.
   wire logic ready_ok = !check_on || (breaker_ready_input && !ready_run_q);  // [RQ1] [RQ3] [RQ4]
   wire logic do_close = dead_wait_q && ready_ok && seq_in.sync_release &&
                         !ext_fail && state_q == st_running;                 // [RQ7]

   wire logic dropout = zone_on && pickup_q && !low_set_pickup;

   wire logic aw_take = s_axi_awvalid && s_axi_awready;
   wire logic w_take  = s_axi_wvalid && s_axi_wready;
   wire logic do_wr   = aw_got_q && w_got_q && !s_axi_bvalid;

   // AXI write channel capture; address and data may come in either order.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else if (clk_en) begin
         s_axi_awready <= !aw_got_q && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !w_got_q && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:0];
         end
         if (w_take) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q[1:0] != 2'h0 || aw_addr_q > `REG_STATUS)
                            ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Setting registers; the status register is read only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q      <= 8'h01;
         ready_tmo_q <= TW'(`READY_TMO_RST);
         ext_limit_q <= TW'(`EXT_LIMIT_RST);
         trip_tmo_q  <= TW'(`TRIP_TMO_RST);
         hold_time_q <= TW'(`HOLD_TIME_RST);
         for (int i = 0; i < 4; i++) begin
            cyc_set_q[i] <= 16'h0000;
         end
      end else if (clk_en && do_wr) begin
         unique case (aw_addr_q)
            `REG_CTRL: begin
               if (w_strb_q[0]) begin
                  ctrl_q <= w_data_q[7:0];
               end
            end
            `REG_READY_TMO: ready_tmo_q <= merge16(ready_tmo_q, w_data_q, w_strb_q);
            `REG_EXT_LIMIT: ext_limit_q <= merge16(ext_limit_q, w_data_q, w_strb_q);  // [RQ9]
            `REG_TRIP_TMO:  trip_tmo_q  <= merge16(trip_tmo_q, w_data_q, w_strb_q);
            `REG_HOLD_TIME: hold_time_q <= merge16(hold_time_q, w_data_q, w_strb_q);
            `REG_CYCLE_CTRL0: begin
               if (w_strb_q[1:0] == 2'h3) begin
                  cyc_set_q[0] <= w_data_q[15:0];
               end
               if (w_strb_q[3:2] == 2'h3) begin
                  cyc_set_q[1] <= w_data_q[31:16];
               end
            end
            `REG_CYCLE_CTRL1: begin
               if (w_strb_q[1:0] == 2'h3) begin
                  cyc_set_q[2] <= w_data_q[15:0];
               end
               if (w_strb_q[3:2] == 2'h3) begin
                  cyc_set_q[3] <= w_data_q[31:16];
               end
            end
            default: ;
         endcase
      end
   end

   // AXI read channel, one cycle after the address is taken.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            unique case (s_axi_araddr[7:0])
               `REG_CTRL:        s_axi_rdata <= {24'h000000, ctrl_q};
               `REG_READY_TMO:   s_axi_rdata <= 32'(ready_tmo_q);
               `REG_EXT_LIMIT:   s_axi_rdata <= 32'(ext_limit_q);
               `REG_TRIP_TMO:    s_axi_rdata <= 32'(trip_tmo_q);
               `REG_HOLD_TIME:   s_axi_rdata <= 32'(hold_time_q);
               `REG_CYCLE_CTRL0: s_axi_rdata <= {cyc_set_q[1], cyc_set_q[0]};
               `REG_CYCLE_CTRL1: s_axi_rdata <= {cyc_set_q[3], cyc_set_q[2]};
               `REG_STATUS:      s_axi_rdata <= {22'h000000, cycle_q, state_q,
                                    breaker_failure, dynamic_block_flag,
                                    hold_run_q, trip_run_q, ext_run_q, ready_run_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Breaker ready timeout timer.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ready_q     <= 1'b1;
         ready_run_q <= 1'b0;
         ready_cnt_q <= '0;
      end else if (clk_en) begin
         ready_q <= breaker_ready_input;
         if (general_reset || !check_on || breaker_ready_input) begin
            ready_run_q <= 1'b0;                                 // [RQ3] [RQ24]
         end else if (ready_q && !breaker_ready_input) begin
            ready_run_q <= 1'b1;                                 // [RQ2] [RQ24]
            ready_cnt_q <= ready_tmo_q;
         end else if (ready_run_q && tick) begin
            ready_cnt_q <= ready_cnt_q - 1'b1;
            if (ready_exp) begin
               ready_run_q <= 1'b0;
            end
         end
      end
   end

   // Dead time extension limit timer.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dead_wait_q <= 1'b0;
         ext_run_q   <= 1'b0;
         ext_cnt_q   <= '0;
      end else if (clk_en) begin
         if (general_reset || do_close || ext_exp || !running) begin
            dead_wait_q <= 1'b0;                                 // [RQ7] [RQ24]
            ext_run_q   <= 1'b0;
         end else if (seq_in.dead_time_done && !dead_wait_q) begin
            dead_wait_q <= 1'b1;                                 // [RQ6]
            ext_run_q   <= 1'b1;
            ext_cnt_q   <= ext_limit_q;
         end else if (ext_run_q && tick) begin
            ext_cnt_q <= ext_cnt_q - 1'b1;
         end
      end
   end

   // Trip-to-open timer.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trip_run_q      <= 1'b0;
         trip_cnt_q      <= '0;
         breaker_failure <= 1'b0;
      end else if (clk_en) begin
         if (general_reset) begin
            trip_run_q      <= 1'b0;                             // [RQ24]
            breaker_failure <= 1'b0;
         end else if (seq_in.breaker_open || trip_tmo_q == TW'(`TIMER_INFINITE)) begin
            trip_run_q <= 1'b0;                                  // [RQ12]
         end else if (seq_in.trip && !trip_run_q) begin
            trip_run_q <= 1'b1;                                  // [RQ10]
            trip_cnt_q <= trip_tmo_q;
         end else if (trip_run_q && tick) begin
            trip_cnt_q <= trip_cnt_q - 1'b1;
            if (trip_exp) begin
               trip_run_q      <= 1'b0;
               breaker_failure <= 1'b1;                          // [RQ11]
            end
         end
         // A failure raised in this very cycle must not be wiped by the idle clear.
         if (state_q == st_normal && !dynamic_block_flag && !trip_exp) begin
            breaker_failure <= 1'b0;
         end
      end
   end

   // Dynamic blocking hold timer.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dynamic_block_flag <= 1'b0;
         hold_run_q         <= 1'b0;
         hold_cnt_q         <= '0;
      end else if (clk_en) begin
         if (general_reset) begin
            dynamic_block_flag <= 1'b0;                          // [RQ24]
            hold_run_q         <= 1'b0;
         end else if (new_cause) begin
            dynamic_block_flag <= 1'b1;                          // [RQ5] [RQ8] [RQ11]
            hold_run_q         <= 1'b1;
            hold_cnt_q         <= hold_time_q;
         end else if (hold_run_q && tick) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
            if (hold_exp) begin
               if (seq_in.extra_block || (check_on && !breaker_ready_input)) begin
                  hold_cnt_q <= hold_time_q;                     // [RQ23]
               end else begin
                  hold_run_q         <= 1'b0;
                  dynamic_block_flag <= 1'b0;                    // [RQ23]
               end
            end
         end
      end
   end

   // Reclose state and cycle count.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= st_normal;
         cycle_q       <= 2'h0;
         pickup_q      <= 1'b0;
         close_command <= 1'b0;
      end else if (clk_en) begin
         pickup_q      <= low_set_pickup;
         close_command <= do_close;
         if (general_reset) begin
            state_q <= st_normal;
            cycle_q <= 2'h0;
         end else if (new_cause) begin
            state_q <= st_blocked;
         end else begin
            unique case (state_q)
               st_normal: begin
                  cycle_q <= 2'h0;                               // [RQ17]
                  if (seq_in.trip || dropout) begin
                     state_q <= st_running;
                  end
                  if (dropout) begin
                     cycle_q <= 2'h1;                            // [RQ22]
                  end
               end
               st_running: begin
                  if (do_close || dropout) begin
                     cycle_q <= (cycle_q == 2'h3) ? cycle_q : cycle_q + 2'h1;  // [RQ18] [RQ21] [RQ22]
                  end
                  if (seq_in.restraint_done) begin
                     state_q <= st_normal;                       // [RQ19]
                     cycle_q <= 2'h0;
                  end
               end
               st_blocked: begin
                  if (!dynamic_block_flag) begin
                     state_q <= st_normal;                       // [RQ19]
                     cycle_q <= 2'h0;
                  end
               end
               default: state_q <= st_normal;
            endcase
         end
      end
   end

   // Element control and indications from the active cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         elem_ctl                <= '0;
         cycle_zone_release_flag <= 4'h0;
         reclose_ready           <= 1'b0;
         reclose_not_ready       <= 1'b1;
         high_set2_enable        <= 1'b1;
         high_set3_enable        <= 1'b1;
      end else if (clk_en) begin
         elem_ctl                <= elem_set_t'(cyc_set_q[cycle_q]);  // [RQ13] [RQ20]
         cycle_zone_release_flag <= (state_q == st_running) ? 4'(1 << cycle_q) : 4'h0;  // [RQ16]
         reclose_ready     <= state_q == st_normal && !dynamic_block_flag;  // [RQ14]
         reclose_not_ready <= !(state_q == st_normal && !dynamic_block_flag);
         high_set2_enable  <= !ctrl_q[`CTRL_HS2_BIT] || (state_q == st_normal);  // [RQ15]
         high_set3_enable  <= !ctrl_q[`CTRL_HS3_BIT] || (state_q == st_normal);
      end
   end

endmodule

`default_nettype wire

/* File: bench/reclose_monitor_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module reclose_monitor_sva
   import reclose_monitor_pkg::*;
#(
   parameter int TW = 16
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        general_reset,
   input wire logic        breaker_ready_input,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        close_command,
   input wire logic        dynamic_block_flag,
   input wire logic        breaker_failure,
   input wire logic        reclose_ready,
   input wire logic        reclose_not_ready,
   input wire logic [3:0]  cycle_zone_release_flag,
   input wire elem_set_t   elem_ctl
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_ready_pair: assert property (reclose_ready != reclose_not_ready)
      else $error("ready and not-ready outputs agree");
   chk_close_pulse: assert property (close_command |=> !close_command)
      else $error("close command longer than one cycle");
   chk_close_ready: assert property (close_command |-> $past(breaker_ready_input))
      else $error("close issued while breaker not ready");
   chk_fail_blocks: assert property ($rose(breaker_failure) |-> ##[0:1] dynamic_block_flag)
      else $error("breaker failure without dynamic block");
   chk_zone_onehot: assert property ($onehot0(cycle_zone_release_flag))
      else $error("more than one zone release flag");
   chk_reset_clear: assert property ((general_reset && clk_en) |=>
      (!dynamic_block_flag && !breaker_failure))
      else $error("general reset left a flag set");
   chk_elem_code: assert property (elem_ctl.phase_hi != ctl_spare &&
      elem_ctl.ground_hi != ctl_spare && elem_ctl.phase_lo != ctl_spare &&
      elem_ctl.ground_lo != ctl_spare)
      else $error("element control holds the spare code");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   cov_close: cover property (close_command);
   cov_fail: cover property ($rose(breaker_failure));
   cov_block: cover property ($rose(dynamic_block_flag) && !breaker_failure);
endmodule
bind reclose_monitor reclose_monitor_sva #(.TW(TW)) reclose_monitor_sva_i (.*);
`default_nettype wire

/* File: bench/breaker_model.sv */
`timescale 1ns/10ps
`default_nettype none
module breaker_model #(
   parameter int RECOV = 2
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic tick,
   input  wire logic trip,
   input  wire logic close_command,
   input  wire logic fail_open,
   input  wire logic stuck_ready,
   output logic      breaker_open,
   output logic      breaker_ready_input
);
   int dly_q;
   int rec_q;
   // The mechanism recharges after each close and reports not ready meanwhile.
   assign breaker_ready_input = !stuck_ready && rec_q == 0;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dly_q <= 0;
         rec_q <= 0;
         breaker_open <= 1'b0;
      end else begin
         dly_q <= (trip && !fail_open) ? dly_q + 1 : 0;
         if (dly_q == 3) breaker_open <= 1'b1;
         if (close_command) begin
            breaker_open <= 1'b0;
            rec_q <= RECOV;
         end else if (tick && rec_q > 0) rec_q <= rec_q - 1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "reclose_monitor_cfg.svh"
module tb_top
   import reclose_monitor_pkg::*;
;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   logic clock = 0, rst_n = 0, tick = 0, general_reset = 0, fail_open = 0, stuck_ready = 0;
   logic ready_in, bopen, close_command, dyn, bf, rdy, nrdy, hs2, hs3;
   logic pick = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, got;
   logic [1:0] bresp, rresp, rs;
   logic [3:0] zone;
   logic [31:0] rd;
   seq_in_t si = '0;
   seq_in_t sx;
   elem_set_t ectl;
   int failures = 0, checked = 0, cyc = 0;
   row_t rows[6] = '{'{`REG_READY_TMO, 32'h64, `RESP_OKAY}, '{`REG_EXT_LIMIT, 32'hC8, `RESP_OKAY},
      '{`REG_TRIP_TMO, 32'h32, `RESP_OKAY}, '{`REG_HOLD_TIME, 32'h64, `RESP_OKAY},
      '{32'h20, 32'h0, `RESP_SLVERR}, '{32'h02, 32'h0, `RESP_SLVERR}};
   assign sx = '{trip: si.trip, breaker_open: bopen, dead_time_done: si.dead_time_done,
      sync_release: si.sync_release, close_done: 1'b0, restraint_done: si.restraint_done,
      extra_block: 1'b0};
   always #12.5 clock = ~clock;
   reclose_monitor #(.TW(16)) reclose_monitor_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
      .tick(tick), .general_reset(general_reset), .breaker_ready_input(ready_in), .seq_in(sx),
      .low_set_pickup(pick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .close_command(close_command), .dynamic_block_flag(dyn), .breaker_failure(bf),
      .reclose_ready(rdy), .reclose_not_ready(nrdy), .high_set2_enable(hs2),
      .high_set3_enable(hs3), .cycle_zone_release_flag(zone), .elem_ctl(ectl));
   breaker_model #(.RECOV(2)) breaker_model_i (.clock(clock), .rst_n(rst_n), .tick(tick),
      .trip(si.trip), .close_command(close_command), .fail_open(fail_open),
      .stuck_ready(stuck_ready), .breaker_open(bopen), .breaker_ready_input(ready_in));
   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!((awready || !awvalid) && (wready || !wvalid)));
      bready <= 1'b1;
      do @(posedge clock); while (!bvalid);
      cmp(bresp, `RESP_OKAY);
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0; rready <= 1'b1;
      do @(posedge clock); while (!rvalid);
      d = rdata; r = rresp; rready <= 1'b0;
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         tick <= 1'b1; @(posedge clock);
         tick <= 1'b0; @(posedge clock);
      end
      repeat (3) @(posedge clock);
   endtask
   task automatic clr();
      si <= '0; fail_open <= 1'b0; stuck_ready <= 1'b0; general_reset <= 1'b1;
      @(posedge clock);
      general_reset <= 1'b0;
      repeat (2) @(posedge clock);
      cmp(dyn, 0);
   endtask
   task automatic start();
      si.trip <= 1'b1; repeat (8) @(posedge clock);
      si.trip <= 1'b0; si.dead_time_done <= 1'b1; @(posedge clock);
   endtask
   task automatic watch(input logic [31:0] exp);
      got = 0;
      repeat (20) begin @(posedge clock); if (close_command === 1'b1) got = 1; end
      cmp(got, exp);
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin failures++; summarize(); end
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      cmp({dyn, bf, nrdy, ectl}, {3'b001, 8'h00});
      repeat (2) @(posedge clock);
      foreach (rows[i]) begin
         axr(rows[i].a, rd, rs);
         cmp({rd, rs}, {rows[i].d, rows[i].r});
      end
      axr(`REG_CTRL, rd, rs);
      cmp(rd[`CTRL_CHECK_BIT], 1);
      axw(`REG_READY_TMO, 32'h3);
      axw(`REG_EXT_LIMIT, 32'h5);
      axw(`REG_TRIP_TMO, `TIMER_INFINITE);
      axr(`REG_EXT_LIMIT, rd, rs);
      cmp(rd, 32'h5);
      fail_open <= 1'b1; si.trip <= 1'b1; tk(12);
      cmp({bf, dyn}, 2'b00);
      clr();
      axw(`REG_TRIP_TMO, 32'h4);
      fail_open <= 1'b1; si.trip <= 1'b1; @(posedge clock); tk(3);
      cmp(bf, 0);
      tk(1);
      cmp({bf, dyn}, 2'b11);
      clr();
      cmp(bf, 0);
      axw(`REG_TRIP_TMO, `TIMER_INFINITE);
      start(); si.sync_release <= 1'b1;
      watch(1);
      cmp({dyn, zone}, 5'h02);
      si <= '{restraint_done: 1'b1, default: 1'b0}; tk(2);
      cmp(dyn, 0);
      clr();
      start(); stuck_ready <= 1'b1; si.sync_release <= 1'b1;
      watch(0);
      tk(2);
      cmp(dyn, 0);
      tk(1);
      cmp(dyn, 1);
      clr();
      start(); tk(4);
      cmp(dyn, 0);
      tk(1);
      cmp(dyn, 1);
      clr();
      axw(`REG_CTRL, 32'h7);
      axw(`REG_CYCLE_CTRL0, 32'h0060_0008);
      pick <= 1'b1; @(posedge clock);
      cmp({rdy, nrdy, hs2, hs3, ectl}, 12'hB08);
      pick <= 1'b0; repeat (3) @(posedge clock);
      cmp({rdy, nrdy, hs2, hs3, zone, ectl}, 16'h5260);
      pick <= 1'b1; @(posedge clock);
      pick <= 1'b0; repeat (3) @(posedge clock);
      cmp({zone, ectl}, 12'h400);
      clr();
      cmp({zone, ectl}, 12'h008);
      summarize();
   end
endmodule
`default_nettype wire
